// >>> bench/pcpr_host_model.sv
// pcpr_host_model.sv: two-wire bus host that reaches the register bank
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module pcpr_host_model (
    input wire logic clk, // pacing clock
    output logic scl, // serial clock, stands high outside frames
    output logic sda_low, // high while pulling data low
    input wire logic sda // resolved data line
);
    initial scl = 1'b1;
    initial sda_low = 1'b0;
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data moves a few cycles after the clock falls so the device sees no false start
    task automatic clk_bit(input logic b, output logic s);
        w(4);
        sda_low = !b;
        w(12);
        scl = 1'b1;
        w(16);
        s = sda;
        scl = 1'b0;
    endtask
    task automatic xbyte(input logic [7:0] o, input logic ack_out, output logic [7:0] i, output logic s);
        for (int k = 7; k >= 0; k--)
            clk_bit(o[k], i[k]);
        clk_bit(ack_out, s);
    endtask
    task automatic start();
        sda_low = 1'b1;
        w(16);
        scl = 1'b0;
    endtask
    task automatic stop();
        w(4);
        sda_low = 1'b1;
        w(12);
        scl = 1'b1;
        w(16);
        sda_low = 1'b0;
        w(16);
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic more, input logic [7:0] d,
                      output logic ok);
        logic [7:0] i;
        logic s0, s1, s2;
        start();
        xbyte({dev, 1'b0}, 1'b1, i, s0);
        xbyte(a, 1'b1, i, s1);
        s2 = 1'b0;
        if (more)
            xbyte(d, 1'b1, i, s2);
        stop();
        ok = !(s0 | s1 | s2);
    endtask
    // single byte read, ended by a not-acknowledge
    task automatic rd(input logic [6:0] dev, output logic [7:0] d, output logic ok);
        logic s0, s1;
        start();
        xbyte({dev, 1'b1}, 1'b1, d, s0);
        xbyte(8'hFF, 1'b1, d, s1);
        stop();
        ok = !s0;
    endtask
endmodule // pcpr_host_model
`default_nettype wire

// >>> bench/tb_poe_config_pushbutton_regs.sv
// tb_poe_config_pushbutton_regs.sv: self-checking bench of the register bank
// assumes the host model on the serial pins; event inputs driven here
`timescale 1ns/1ps
`default_nettype none
module tb_poe_config_pushbutton_regs;
    import pcpr_pkg::*;
    localparam logic [6:0] DEV = 7'h20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic auto_pin = 1'b0, int_cond = 1'b0, osc_fail_raw = 1'b0;
    logic scl, host_low, sda_o, sda_oe_n, int_o, int_oe_n, osc_fail_set, events_clear_all, chip_reset;
    pcpr_port_vec_t cut_current_threshold_fault = 4'h0, start_fault = 4'h0, disc_event = 4'h0, cut_current_threshold_timer_zero = 4'hF;
    pcpr_port_vec_t port_power_on, det_enable, cls_enable, det_start, cls_start, port_clear;
    logic [1:0] dis_sel, cut_current_threshold_sel, start_sel;
    logic [7:0] mode_seen;
    int n_errors = 0, n_tests = 0, n_det = 0, n_cls = 0, n_clr = 0, n_eca = 0, n_crst = 0;
    wire logic sda = !host_low && (sda_oe_n || sda_o);
    always #2.5 clk = !clk;
    always @(posedge clk)
    begin
        n_det += (det_start == 4'h1);
        n_cls += (cls_start == 4'h1);
        n_clr += port_clear[0];
        n_eca += events_clear_all;
        n_crst += chip_reset;
    end
    pcpr_regs #(.DEV_ADDR(DEV)) uut (.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .auto_pin(auto_pin), .int_o(int_o), .int_oe_n(int_oe_n), .int_cond(int_cond),
        .osc_fail_raw(osc_fail_raw), .osc_fail_set(osc_fail_set), .cut_current_threshold_fault(cut_current_threshold_fault),
        .start_fault(start_fault), .disc_event(disc_event), .cut_current_threshold_timer_zero(cut_current_threshold_timer_zero),
        .port_power_on(port_power_on), .det_enable(det_enable), .cls_enable(cls_enable), .det_start(det_start),
        .cls_start(cls_start), .port_clear(port_clear), .events_clear_all(events_clear_all),
        .chip_reset(chip_reset), .port_mode(mode_seen), .disconnect_delay_sel(dis_sel), .cut_current_threshold_limit_sel(cut_current_threshold_sel),
        .startup_time_limit_sel(start_sel));
    pcpr_host_model host (.clk(clk), .scl(scl), .sda_low(host_low), .sda(sda));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host.wr(DEV, a, 1'b1, d, ok);
        chk("write ack", 8'h01, {7'h00, ok});
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        logic ok;
        logic [7:0] got;
        host.wr(DEV, a, 1'b0, 8'h00, ok);
        host.rd(DEV, got, ok);
        chk("read ack", 8'h01, {7'h00, ok});
        chk("read data", exp, got);
    endtask
    task automatic tally_and_finish();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // whole run is near 33k cycles
    initial
    begin
        repeat (90000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end
    initial
    begin
        logic ok;
        logic [7:0] d;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
        rreg(8'h17, 8'hA0);
        rreg(8'h12, 8'h00);
        wreg(8'h16, 8'h3F);
        rreg(8'h16, 8'h3F);
        chk("timing fields", 8'h3F, {2'h0, start_sel, cut_current_threshold_sel, dis_sel});
        for (int a = 8'h18; a <= 8'h1A; a++)
            rreg(a[7:0], 8'h00);
        wreg(8'h17, 8'h00);
        osc_fail_raw = 1'b1;
        int_cond = 1'b1;
        host.rd(7'h0C, d, ok);
        chk("masked osc and int", 8'h01, {5'h00, ok, osc_fail_set, int_oe_n});
        wreg(8'h17, 8'hA0);
        host.rd(7'h0C, d, ok);
        chk("alert reply", {DEV, 1'b1}, d);
        chk("osc and int", 8'h06, {5'h00, ok, osc_fail_set, int_oe_n});
        wreg(8'h1A, 8'h40);
        chk("released int", 8'h01, {7'h00, int_oe_n});
        int_cond = 1'b0;
        repeat (4) @(negedge clk);
        int_cond = 1'b1;
        repeat (4) @(negedge clk);
        chk("int again", 8'h00, {6'h00, int_o, int_oe_n});
        wreg(8'h1A, 8'h80);
        chk("clear all pulses", 8'h01, n_eca[7:0]);
        int_cond = 1'b0;
        wreg(8'h12, 8'h39);
        chk("mode", 8'h39, mode_seen);
        wreg(8'h14, 8'h11);
        wreg(8'h18, 8'hFF);
        chk("start pulses", 8'h22, {n_cls[3:0], n_det[3:0]});
        rreg(8'h14, 8'h77);
        chk("enables", 8'h66, {cls_enable, det_enable});
        wreg(8'h19, 8'h0F);
        chk("power on", 8'h07, {4'h0, port_power_on});
        @(negedge clk) disc_event = 4'h2;
        @(negedge clk) disc_event = 4'h0;
        cut_current_threshold_timer_zero = 4'hB;
        cut_current_threshold_fault = 4'h4;
        @(negedge clk) cut_current_threshold_fault = 4'h0;
        wreg(8'h19, 8'h04);
        chk("faulted power", 8'h01, {4'h0, port_power_on});
        cut_current_threshold_timer_zero = 4'hF;
        repeat (2) @(negedge clk);
        wreg(8'h19, 8'h04);
        chk("power back", 8'h05, {4'h0, port_power_on});
        n_clr = 0;
        wreg(8'h19, 8'h10);
        chk("power off", 8'h41, {port_power_on, n_clr[3:0]});
        wreg(8'h1A, 8'h04);
        rreg(8'h14, 8'h22);
        chk("port reset power", 8'h00, {4'h0, port_power_on});
        wreg(8'h1A, 8'h20);
        rreg(8'h14, 8'h22);
        chk("no chip reset", 8'h00, n_crst[7:0]);
        wreg(8'h17, 8'h00);
        auto_pin = 1'b1;
        wreg(8'h1A, 8'h10);
        repeat (8) @(negedge clk);
        chk("chip reset", 8'h01, n_crst[7:0]);
        rreg(8'h16, 8'h00);
        rreg(8'h17, 8'hA0);
        rreg(8'h12, 8'hFF);
        rreg(8'h14, 8'hFF);
        tally_and_finish();
    end
endmodule // tb_poe_config_pushbutton_regs
`default_nettype wire

// >>> rtl/pcpr_bus_if.sv
// pcpr_bus_if.sv: register access between serial front end and register bank
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface pcpr_bus_if;
    logic wr_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ara_en;
    modport slave (output wr_stb, output addr, output wdata, input rdata, input ara_en);
    modport regs (input wr_stb, input addr, input wdata, output rdata, output ara_en);
endinterface // pcpr_bus_if
`default_nettype wire

// >>> rtl/pcpr_i2c_slave.sv
// pcpr_i2c_slave.sv: two-wire serial slave, one pointer byte then data bytes
// assumes scl/sda are asynchronous pins, oversampled by clk
`timescale 1ns/1ps
`default_nettype none
`include "pcpr_map.svh"
module pcpr_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = `PCPR_DEV_ADDR // own address
)(
    input wire logic clk, // core clock
    input wire logic resetn, // async reset, low
    input wire logic scl_i, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // data drive value
    output logic sda_oe_n, // low while pulling data low
    pcpr_bus_if.slave bus // register access
);
    import pcpr_pkg::*;
    logic [1:0] scl_ff, sda_ff;
    logic scl_d, sda_d, drv_reg, wr_reg, rw_reg, first_reg, ara_reg, ack_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sh_reg, ptr_reg, wd_reg;
    pcpr_i2c_st_t st_reg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            scl_ff <= 2'h3;
            sda_ff <= 2'h3;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_ff <= {scl_ff[0], scl_i};
            sda_ff <= {sda_ff[0], sda_i};
            scl_d <= scl_ff[1];
            sda_d <= sda_ff[1];
        end
    end
    wire scl_s = scl_ff[1];
    wire sda_s = sda_ff[1];
    wire rise = scl_s & ~scl_d;
    wire fall = ~scl_s & scl_d;
    wire start = scl_s & scl_d & sda_d & ~sda_s;
    wire stop = scl_s & scl_d & ~sda_d & sda_s;
    wire full = cnt_reg == 4'h8;
    wire adr_hit = sh_reg[7:1] == DEV_ADDR;
    // alert response only answered while the bank allows it
    wire ara_hit = bus.ara_en & (sh_reg[7:1] == `PCPR_ARA) & sh_reg[0];
    wire [7:0] tx_byte = ara_reg ? {DEV_ADDR, 1'b1} : bus.rdata;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg <= PCPR_ST_IDLE;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            ptr_reg <= 8'h00;
            wd_reg <= 8'h00;
            drv_reg <= 1'b0;
            wr_reg <= 1'b0;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            ara_reg <= 1'b0;
            ack_reg <= 1'b0;
        end
        else
        begin
            wr_reg <= 1'b0;
            if (start)
            begin
                st_reg <= PCPR_ST_ADDR;
                cnt_reg <= 4'h0;
                drv_reg <= 1'b0;
            end
            else if (stop)
            begin
                st_reg <= PCPR_ST_IDLE;
                drv_reg <= 1'b0;
            end
            else if (rise)
            begin
                if (st_reg == PCPR_ST_ADDR || st_reg == PCPR_ST_RX)
                begin
                    sh_reg <= {sh_reg[6:0], sda_s};
                    cnt_reg <= cnt_reg + 4'h1;
                end
                if (st_reg == PCPR_ST_TXACK)
                    ack_reg <= ~sda_s;
            end
            else if (fall)
            begin
                case (st_reg)
                    PCPR_ST_ADDR:
                        if (full)
                        begin
                            cnt_reg <= 4'h0;
                            rw_reg <= sh_reg[0];
                            ara_reg <= ara_hit;
                            drv_reg <= adr_hit | ara_hit;
                            st_reg <= (adr_hit | ara_hit) ? PCPR_ST_AACK : PCPR_ST_IDLE;
                        end
                    PCPR_ST_AACK:
                        if (rw_reg)
                        begin
                            st_reg <= PCPR_ST_TX;
                            sh_reg <= {tx_byte[6:0], 1'b0};
                            drv_reg <= ~tx_byte[7];
                            cnt_reg <= 4'h1;
                        end
                        else
                        begin
                            st_reg <= PCPR_ST_RX;
                            drv_reg <= 1'b0;
                            first_reg <= 1'b1;
                        end
                    PCPR_ST_RX:
                        if (full)
                        begin
                            st_reg <= PCPR_ST_RXACK;
                            drv_reg <= 1'b1;
                            cnt_reg <= 4'h0;
                            first_reg <= 1'b0;
                            if (first_reg)
                                ptr_reg <= sh_reg;
                            else
                            begin
                                wd_reg <= sh_reg;
                                wr_reg <= 1'b1;
                            end
                        end
                    PCPR_ST_RXACK:
                    begin
                        st_reg <= PCPR_ST_RX;
                        drv_reg <= 1'b0;
                    end
                    PCPR_ST_TX:
                        if (full)
                        begin
                            st_reg <= PCPR_ST_TXACK;
                            drv_reg <= 1'b0;
                        end
                        else
                        begin
                            drv_reg <= ~sh_reg[7];
                            sh_reg <= {sh_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    PCPR_ST_TXACK:
                        if (ack_reg)
                        begin
                            st_reg <= PCPR_ST_TX;
                            sh_reg <= {tx_byte[6:0], 1'b0};
                            drv_reg <= ~tx_byte[7];
                            cnt_reg <= 4'h1;
                        end
                        else
                            st_reg <= PCPR_ST_IDLE;
                    default:
                        drv_reg <= 1'b0;
                endcase
            end
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe_n = ~drv_reg;
    assign bus.wr_stb = wr_reg;
    assign bus.addr = ptr_reg;
    assign bus.wdata = wd_reg;
endmodule // pcpr_i2c_slave
`default_nettype wire

// >>> rtl/pcpr_map.svh
// pcpr_map.svh: offsets, field positions and reset values of the register bank
// assumes inclusion by bare name from rtl/
`ifndef PCPR_MAP_SVH
`define PCPR_MAP_SVH
`define PCPR_A_MODE 8'h12
`define PCPR_A_DCE 8'h14
`define PCPR_A_TIM 8'h16
`define PCPR_A_MISC 8'h17
`define PCPR_A_RESTART 8'h18
`define PCPR_A_PWR 8'h19
`define PCPR_A_RST 8'h1A
`define PCPR_TIM_DIS_LSB 0
`define PCPR_TIM_CUT_CURRENT_THRESHOLD_LSB 2
`define PCPR_TIM_START_LSB 4
`define PCPR_TIM_WMASK 8'h3F
`define PCPR_MISC_OSCMASK 5
`define PCPR_MISC_INTEN 7
`define PCPR_MISC_WMASK 8'hA0
`define PCPR_MISC_DFLT 8'hA0
`define PCPR_TIM_DFLT 8'h00
`define PCPR_MODE_DFLT_HI 8'hFF
`define PCPR_MODE_DFLT_LO 8'h00
`define PCPR_DCE_DFLT_HI 8'hFF
`define PCPR_DCE_DFLT_LO 8'h00
`define PCPR_RST_ALL 4
`define PCPR_RST_REL 6
`define PCPR_RST_EVCLR 7
`define PCPR_INIT_CNT 2'h3
`define PCPR_ARA 7'h0C
`define PCPR_DEV_ADDR 7'h20
`endif

// >>> rtl/pcpr_pkg.sv
// pcpr_pkg.sv: types shared by the register bank and its serial front end
// assumes nothing of its surroundings
package pcpr_pkg;
    typedef logic [3:0] pcpr_port_vec_t;
    typedef enum logic [1:0] {
        PCPR_MODE_SHDN = 2'h0,
        PCPR_MODE_MAN = 2'h1,
        PCPR_MODE_SEMI = 2'h2,
        PCPR_MODE_AUTO = 2'h3
    } pcpr_mode_t;
    typedef enum logic [2:0] {
        PCPR_ST_IDLE = 3'h0,
        PCPR_ST_ADDR = 3'h1,
        PCPR_ST_AACK = 3'h3,
        PCPR_ST_RX = 3'h2,
        PCPR_ST_RXACK = 3'h6,
        PCPR_ST_TX = 3'h7,
        PCPR_ST_TXACK = 3'h5
    } pcpr_i2c_st_t;
endpackage

// >>> rtl/pcpr_regs.sv
// pcpr_regs.sv: configuration and pushbutton registers of a quad port power controller
// assumes fault and event inputs come from logic on clk; serial pins and the strap are asynchronous
// Overview of operation
// - enable bits gate detect/class in auto modes
// - manual mode enable write runs one cycle
// - timing bits 0-1 select disconnect delay
// - timing bits 2-3 select overcurrent limit
// - timing bits 4-5 select start-up limit
// - timing bits 6-7 written zero, read zero
// - misc bit 5 masks oscillator fail
// - misc bit 7 enables interrupt and alert
// - pushbuttons write-only, ones act, read 00h
// - restart pushbutton starts one manual cycle
// - restart pushbutton sets auto-mode enable bits
// - power pushbutton sets or clears power flag
// - faults and disconnects still remove power
// - no power-on until overcurrent timer expires
// - power-off pushbutton clears port state too
// - reset bits 0-3 clear one port
// - reset bit 4 returns chip to defaults
// - reset bit 5 has no effect
// - reset bit 6 releases interrupt only
// - reset bit 7 releases, clears all events
// - each port has one of four modes
// - shutdown port holds power and enables at zero, clears events; lockout kept
`timescale 1ns/1ps
`default_nettype none
`include "pcpr_map.svh"
module pcpr_regs #(
    parameter logic [6:0] DEV_ADDR = `PCPR_DEV_ADDR // serial address
)(
    input wire logic clk, // 200 MHz core clock
    input wire logic resetn, // async reset, low
    input wire logic scl_i, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // data drive value
    output logic sda_oe_n, // low while pulling data
    input wire logic auto_pin, // autonomous start strap
    output logic int_o, // interrupt drive value
    output logic int_oe_n, // low while pulling interrupt
    input wire logic int_cond, // pending interrupt condition
    input wire logic osc_fail_raw, // reference input missing
    output logic osc_fail_set, // sets oscillator fail flag
    input wire pcpr_pkg::pcpr_port_vec_t cut_current_threshold_fault, // overcurrent timeout pulse
    input wire pcpr_pkg::pcpr_port_vec_t start_fault, // start-up fault pulse
    input wire pcpr_pkg::pcpr_port_vec_t disc_event, // enabled disconnect pulse
    input wire pcpr_pkg::pcpr_port_vec_t cut_current_threshold_timer_zero, // timer back at zero
    output pcpr_pkg::pcpr_port_vec_t port_power_on, // power-on flags
    output pcpr_pkg::pcpr_port_vec_t det_enable, // detection allowed
    output pcpr_pkg::pcpr_port_vec_t cls_enable, // classification allowed
    output pcpr_pkg::pcpr_port_vec_t det_start, // one detection cycle
    output pcpr_pkg::pcpr_port_vec_t cls_start, // one classification cycle
    output pcpr_pkg::pcpr_port_vec_t port_clear, // clear port events/status
    output logic events_clear_all, // clear all event registers
    output logic chip_reset, // whole-chip reset pulse
    output logic [7:0] port_mode, // two mode bits per port
    output logic [1:0] disconnect_delay_sel, // disconnect delay code
    output logic [1:0] cut_current_threshold_limit_sel, // overcurrent limit code
    output logic [1:0] startup_time_limit_sel // start-up limit code
);
    import pcpr_pkg::*;

    pcpr_bus_if bus ();

    pcpr_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_i2c (
        .clk(clk),
        .resetn(resetn),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .bus(bus)
    );

    logic [1:0] auto_ff;
    logic [1:0] init_reg;
    logic [7:0] mode_reg, dce_reg, tim_reg, misc_reg;
    pcpr_port_vec_t pwr_reg, lock_reg, det_reg, cls_reg, clr_reg;
    logic rel_reg, drv_reg, osc_reg, evclr_reg, chip_reg;
    pcpr_port_vec_t is_shdn, is_man, is_aut;

    // strap resynchronised; defaults load once it has settled
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            auto_ff <= 2'h0;
        else
            auto_ff <= {auto_ff[0], auto_pin};
    end
    wire auto_s = auto_ff[1];

    // decode
    wire live = init_reg == 2'h0;
    wire wr = bus.wr_stb & live;
    wire [7:0] wd = bus.wdata;
    wire w_mode = wr & (bus.addr == `PCPR_A_MODE);
    wire w_dce = wr & (bus.addr == `PCPR_A_DCE);
    wire w_tim = wr & (bus.addr == `PCPR_A_TIM);
    wire w_misc = wr & (bus.addr == `PCPR_A_MISC);
    wire w_restart = wr & (bus.addr == `PCPR_A_RESTART);
    wire w_pwr = wr & (bus.addr == `PCPR_A_PWR);
    wire w_rst = wr & (bus.addr == `PCPR_A_RST);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_mode
            pcpr_mode_t m;
            assign m = pcpr_mode_t'(mode_reg[2*gi +: 2]);
            assign is_shdn[gi] = m == PCPR_MODE_SHDN;
            assign is_man[gi] = m == PCPR_MODE_MAN;
            assign is_aut[gi] = (m == PCPR_MODE_SEMI) | (m == PCPR_MODE_AUTO);
        end
    endgenerate

    // pushbuttons are pure decodes of the write strobe, nothing stored
    wire [7:0] pb_restart = w_restart ? wd : 8'h00;
    wire [3:0] pb_on = w_pwr ? wd[3:0] : 4'h0;
    wire [3:0] pb_off = w_pwr ? wd[7:4] : 4'h0;
    wire [3:0] pb_prst = w_rst ? wd[3:0] : 4'h0;
    wire pb_all = w_rst & wd[`PCPR_RST_ALL];
    // bit 5 of the reset pushbutton is decoded by nobody
    wire pb_rel = w_rst & wd[`PCPR_RST_REL];
    wire pb_evclr = w_rst & wd[`PCPR_RST_EVCLR];

    wire [3:0] flt = cut_current_threshold_fault | start_fault;
    wire [3:0] kill = pb_off | pb_prst | {4{pb_all}};
    wire [3:0] clr = kill | is_shdn;

    wire [7:0] dce_wr = w_dce ? wd : dce_reg;
    wire [7:0] dce_next = (dce_wr | (pb_restart & {is_aut, is_aut})) & ~{clr, clr};
    // manual ports: a written one is a single cycle request
    wire [7:0] one_shot = ((w_dce ? wd : 8'h00) | pb_restart) & {is_man, is_man};

    // a fault in the same cycle as power-on wins, and faults latch a lockout
    wire [3:0] pwr_set = pb_on & ~is_shdn & ~lock_reg & ~flt;
    wire [3:0] pwr_next = (pwr_reg | pwr_set) & ~(clr | flt | disc_event);
    wire [3:0] lock_next = flt | (lock_reg & ~cut_current_threshold_timer_zero);

    wire [7:0] mode_next = w_mode ? wd : mode_reg;
    wire [7:0] tim_next = w_tim ? (wd & `PCPR_TIM_WMASK) : tim_reg;
    wire [7:0] misc_next = w_misc ? (wd & `PCPR_MISC_WMASK) : misc_reg;

    // release holds until the condition goes away; a new release wins a clear
    wire rel_next = pb_rel | (rel_reg & int_cond & ~pb_evclr);
    wire drv_next = misc_next[`PCPR_MISC_INTEN] & int_cond & ~rel_next & ~pb_evclr & ~pb_all;

    wire [7:0] mode_dflt = auto_s ? `PCPR_MODE_DFLT_HI : `PCPR_MODE_DFLT_LO;
    wire [7:0] dce_dflt = auto_s ? `PCPR_DCE_DFLT_HI : `PCPR_DCE_DFLT_LO;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            init_reg <= `PCPR_INIT_CNT;
        else if (pb_all)
            init_reg <= `PCPR_INIT_CNT;
        else if (!live)
            init_reg <= init_reg - 2'h1;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_reg <= 8'h00;
            dce_reg <= 8'h00;
            tim_reg <= `PCPR_TIM_DFLT;
            misc_reg <= `PCPR_MISC_DFLT;
        end
        else if (init_reg == 2'h1)
        begin
            mode_reg <= mode_dflt;
            dce_reg <= dce_dflt;
            tim_reg <= `PCPR_TIM_DFLT;
            misc_reg <= `PCPR_MISC_DFLT;
        end
        else
        begin
            mode_reg <= mode_next;
            dce_reg <= dce_next;
            tim_reg <= tim_next;
            misc_reg <= misc_next;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwr_reg <= 4'h0;
            lock_reg <= 4'h0;
        end
        else
        begin
            pwr_reg <= live ? pwr_next : 4'h0;
            lock_reg <= live ? lock_next : 4'h0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rel_reg <= 1'b0;
            drv_reg <= 1'b0;
            osc_reg <= 1'b0;
        end
        else
        begin
            rel_reg <= rel_next;
            drv_reg <= drv_next & live;
            osc_reg <= osc_fail_raw & misc_reg[`PCPR_MISC_OSCMASK];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            det_reg <= 4'h0;
            cls_reg <= 4'h0;
            clr_reg <= 4'h0;
            evclr_reg <= 1'b0;
            chip_reg <= 1'b0;
        end
        else
        begin
            det_reg <= one_shot[3:0];
            cls_reg <= one_shot[7:4];
            clr_reg <= clr;
            evclr_reg <= pb_evclr;
            chip_reg <= pb_all;
        end
    end

    // pushbuttons and unmapped addresses read as zero
    assign bus.rdata = (bus.addr == `PCPR_A_MODE) ? mode_reg :
                       (bus.addr == `PCPR_A_DCE) ? dce_reg :
                       (bus.addr == `PCPR_A_TIM) ? tim_reg :
                       (bus.addr == `PCPR_A_MISC) ? misc_reg : 8'h00;
    assign bus.ara_en = drv_reg;

    assign int_o = 1'b0;
    assign int_oe_n = ~drv_reg;
    assign osc_fail_set = osc_reg;
    assign port_power_on = pwr_reg;
    assign det_enable = dce_reg[3:0] & is_aut;
    assign cls_enable = dce_reg[7:4] & is_aut;
    assign det_start = det_reg;
    assign cls_start = cls_reg;
    assign port_clear = clr_reg;
    assign events_clear_all = evclr_reg;
    assign chip_reset = chip_reg;
    assign port_mode = mode_reg;
    assign disconnect_delay_sel = tim_reg[`PCPR_TIM_DIS_LSB +: 2];
    assign cut_current_threshold_limit_sel = tim_reg[`PCPR_TIM_CUT_CURRENT_THRESHOLD_LSB +: 2];
    assign startup_time_limit_sel = tim_reg[`PCPR_TIM_START_LSB +: 2];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    pb_read_zero_a: assert property ((bus.addr >= `PCPR_A_RESTART) |-> bus.rdata == 8'h00)
        else $error("pushbutton read not zero");
    tim_resv_zero_a: assert property (w_tim |=> tim_reg[7:6] == 2'h0)
        else $error("reserved timing bits set");
    int_gate_a: assert property (!misc_reg[`PCPR_MISC_INTEN] |-> int_oe_n && !bus.ara_en)
        else $error("interrupt driven while disabled");
    pwr_lock_a: assert property ((lock_reg[2] && !pwr_reg[2]) |=> !pwr_reg[2])
        else $error("power set during lockout");
    shdn_off_a: assert property (is_shdn[1] |=> !pwr_reg[1] && dce_reg[5] == 1'b0 && port_clear[1])
        else $error("shutdown port not held clear");
    pwr_off_pb_a: assert property (pb_off[0] |=> !pwr_reg[0] && !dce_reg[0] && !dce_reg[4] && port_clear[0])
        else $error("power off pushbutton incomplete");
    man_start_a: assert property ((w_restart && is_man[0] && wd[0]) |=> det_start[0] ##1 !det_start[0])
        else $error("manual restart not one pulse");
    restart_aut_a: assert property ((w_restart && is_aut[1] && wd[5] && !clr[1]) |=> cls_enable[1])
        else $error("restart did not set enable");
    fault_off_a: assert property ((cut_current_threshold_fault[2] || start_fault[2] || disc_event[2]) |=> !pwr_reg[2])
        else $error("fault left port powered");
    rel_int_a: assert property (pb_rel |=> int_oe_n)
        else $error("interrupt not released");
    evclr_a: assert property (pb_evclr |=> events_clear_all && int_oe_n)
        else $error("event clear pushbutton failed");
    reset_all_a: assert property (pb_all |=> chip_reset && pwr_reg == 4'h0 ##3 misc_reg == `PCPR_MISC_DFLT)
        else $error("chip reset incomplete");

    pwr_on_c: cover property (w_pwr && pwr_set[3] ##1 pwr_reg[3]);
    manual_det_c: cover property (det_start[2]);
    int_release_c: cover property (!int_oe_n ##1 pb_rel ##1 int_oe_n);
    chip_reset_c: cover property (chip_reset);
endmodule // pcpr_regs
`default_nettype wire
